// *** verilog/digest_service_defs.vh ***
`ifndef DIGEST_SERVICE_DEFS_VH
`define DIGEST_SERVICE_DEFS_VH

// Clock
`define CLK_PERIOD_NS        25

// Service command codes
`define CMD_SERIAL_ID        8'h00
`define CMD_USER_CODE        8'h01
`define CMD_DIGEST           8'h47

// Option word bit positions
`define OPT_FABRIC           0
`define OPT_CONFIG_DATA      1
`define OPT_ROM_PAGE         2
`define OPT_USER_SECURITY    3
`define OPT_KEY_PUF          4
`define OPT_KEY_EC           5
`define OPT_KEY_PUB1         6
`define OPT_KEY_ENC1         7
`define OPT_WIDTH            8

// Status codes
`define STATUS_OK            8'h00
`define STATUS_DIGEST_FAIL   8'h01
`define STATUS_NO_AREA       8'h02
`define STATUS_BAD_CMD       8'hFF

// Mailbox word counts
`define SERIAL_WORDS         3'h4
`define USER_CODE_WORDS      3'h1

// Timing
`define DIGEST_TIME_NS       100000
`define DIGEST_CYCLES        ((`DIGEST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUSPEND_SETTLE_NS    100
`define SUSPEND_SETTLE_CYC   ((`SUSPEND_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RELOCK_MAX_NS        50000
`define RELOCK_MAX_CYC       (`RELOCK_MAX_NS / `CLK_PERIOD_NS)
`define LED_TICK_NS          100000000
`define LED_TICK_CYC         (`LED_TICK_NS / `CLK_PERIOD_NS)

// Reset values
`define LED_COUNT_RESET      4'h0
`define STATUS_RESET         8'h00

`endif

// *** verilog/level_sync.v ***
`timescale 1ns/1ps
module level_sync (
  clk_sys,
  rst,
  din,
  dout
);
  input  wire clk_sys;
  input  wire rst;
  input  wire din;
  output reg  dout;

  reg         stage_reg;

  // First stage feeds only the second
  always @(posedge clk_sys) begin
    if (rst) begin
      stage_reg <= 1'b0;
      dout      <= 1'b0;
    end else begin
      stage_reg <= din;
      dout      <= stage_reg;
    end
  end
endmodule

// *** verilog/digest_service_engine.v ***
// Notes on behaviour
// - Fabric digest holds fabric suspended, clocks gated.
// - Digest end leaves suspend, restarts PLLs, clocks.
// - Status zero means digest passed.
// - Serial fetch returns 128-bit unique identifier.
// - User code fetch returns 32-bit signature.
// - Counter freezes, LEDs dark, during fabric digest.
// - Busy during service; status valid in the cycle busy drops.
`timescale 1ns/1ps
`include "digest_service_defs.vh"
module digest_service_engine #(
  parameter [127:0] SERIAL_ID_VALUE = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0, // Arbitrary value
  parameter [31:0]  USER_CODE_VALUE = 32'h13572468, // Arbitrary value
  parameter integer LED_TICK        = `LED_TICK_CYC
) (
  clk_sys,
  rst,
  service_req,
  service_cmd,
  mailbox_write_data,
  digest_fail_in,
  pll_lock_in,
  service_busy,
  status_code,
  status_valid,
  mailbox_read_data,
  mailbox_read_valid,
  flop_restore_flag,
  fabric_clk_en,
  pll_power_down,
  io_input_en,
  led_out
);
  input  wire                    clk_sys;
  input  wire                    rst;
  input  wire                    service_req;
  input  wire [7:0]              service_cmd;
  input  wire [`OPT_WIDTH-1:0]   mailbox_write_data;
  input  wire                    digest_fail_in;
  input  wire                    pll_lock_in;
  output reg                     service_busy;
  output reg  [7:0]              status_code;
  output reg                     status_valid;
  output reg  [31:0]             mailbox_read_data;
  output reg                     mailbox_read_valid;
  output reg                     flop_restore_flag;
  output reg                     fabric_clk_en;
  output reg                     pll_power_down;
  output reg                     io_input_en;
  output reg  [3:0]              led_out;

  localparam [2:0] ST_IDLE    = 3'h0;
  localparam [2:0] ST_SUSPEND = 3'h1;
  localparam [2:0] ST_RUN     = 3'h2;
  localparam [2:0] ST_RESUME  = 3'h3;
  localparam [2:0] ST_RELOCK  = 3'h4;
  localparam [2:0] ST_READ    = 3'h5;
  localparam [2:0] ST_DONE    = 3'h6;

  localparam integer DIGEST_INT = `DIGEST_CYCLES;
  localparam integer SETTLE_INT = `SUSPEND_SETTLE_CYC;
  localparam integer RELOCK_INT = `RELOCK_MAX_CYC;
  localparam [15:0]  DIGEST_CNT = DIGEST_INT[15:0];
  localparam [15:0]  SETTLE_CNT = SETTLE_INT[15:0];
  localparam [15:0]  RELOCK_CNT = RELOCK_INT[15:0];
  localparam [31:0] LED_TICK_W = LED_TICK;

  reg  [2:0]             state_reg;
  reg  [15:0]            timer_reg;
  reg  [`OPT_WIDTH-1:0]  options_reg;
  reg  [7:0]             cmd_reg;
  reg  [2:0]             word_idx_reg;
  reg  [2:0]             word_cnt_reg;
  reg                    fail_reg;
  reg  [31:0]            led_div_reg;
  reg  [3:0]             led_count_reg;
  wire                   digest_fail_sync;
  wire                   pll_lock_sync;
  reg  [31:0]            read_word;

  level_sync fail_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (digest_fail_in),
    .dout    (digest_fail_sync)
  );

  level_sync lock_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (pll_lock_in),
    .dout    (pll_lock_sync)
  );

  // Serial words leave low word first
  always @* begin
    read_word = USER_CODE_VALUE;
    if (cmd_reg == `CMD_SERIAL_ID) begin
      case (word_idx_reg)
        3'h0:    read_word = SERIAL_ID_VALUE[31:0];
        3'h1:    read_word = SERIAL_ID_VALUE[63:32];
        3'h2:    read_word = SERIAL_ID_VALUE[95:64];
        default: read_word = SERIAL_ID_VALUE[127:96];
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      state_reg          <= ST_IDLE;
      timer_reg          <= 16'h0000;
      options_reg        <= {`OPT_WIDTH{1'b0}};
      cmd_reg            <= 8'h00;
      word_idx_reg       <= 3'h0;
      word_cnt_reg       <= 3'h0;
      fail_reg           <= 1'b0;
      service_busy       <= 1'b0;
      status_code        <= `STATUS_RESET;
      status_valid       <= 1'b0;
      mailbox_read_data  <= 32'h00000000;
      mailbox_read_valid <= 1'b0;
      flop_restore_flag  <= 1'b0;
      fabric_clk_en      <= 1'b1;
      pll_power_down     <= 1'b0;
      io_input_en        <= 1'b1;
    end else begin
      status_valid       <= 1'b0;
      mailbox_read_valid <= 1'b0;
      flop_restore_flag  <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          // Requests seen only here, so any made while busy are dropped
          if (service_req) begin
            service_busy <= 1'b1;
            cmd_reg      <= service_cmd;
            options_reg  <= mailbox_write_data;
            fail_reg     <= 1'b0;
            word_idx_reg <= 3'h0;
            timer_reg    <= 16'h0000;
            if (service_cmd == `CMD_SERIAL_ID) begin
              word_cnt_reg <= `SERIAL_WORDS;
              state_reg    <= ST_READ;
            end else if (service_cmd == `CMD_USER_CODE) begin
              word_cnt_reg <= `USER_CODE_WORDS;
              state_reg    <= ST_READ;
            end else if (service_cmd == `CMD_DIGEST) begin
              if (mailbox_write_data == {`OPT_WIDTH{1'b0}}) begin
                status_code <= `STATUS_NO_AREA;
                state_reg   <= ST_DONE;
              end else if (mailbox_write_data[`OPT_FABRIC]) begin
                state_reg   <= ST_SUSPEND;
              end else begin
                state_reg   <= ST_RUN;
              end
            end else begin
              status_code <= `STATUS_BAD_CMD;
              state_reg   <= ST_DONE;
            end
          end
        end
        ST_SUSPEND: begin
          // Clocks low first, then PLLs and input buffers off
          fabric_clk_en <= 1'b0;
          if (timer_reg >= SETTLE_CNT) begin
            pll_power_down <= 1'b1;
            io_input_en    <= 1'b0;
            timer_reg      <= 16'h0000;
            state_reg      <= ST_RUN;
          end else begin
            timer_reg <= timer_reg + 16'h0001;
          end
        end
        ST_RUN: begin
          if (digest_fail_sync) begin
            fail_reg <= 1'b1;
          end
          if (timer_reg >= DIGEST_CNT - 16'h0001) begin
            timer_reg <= 16'h0000;
            if (options_reg[`OPT_FABRIC]) begin
              state_reg <= ST_RESUME;
            end else begin
              state_reg <= ST_DONE;
            end
          end else begin
            timer_reg <= timer_reg + 16'h0001;
          end
        end
        ST_RESUME: begin
          // Leaves suspend with no outside help
          pll_power_down    <= 1'b0;
          io_input_en       <= 1'b1;
          fabric_clk_en     <= 1'b1;
          flop_restore_flag <= 1'b1;
          state_reg         <= ST_RELOCK;
        end
        ST_RELOCK: begin
          // Busy stays high so reset logic masks lock loss meanwhile
          if (pll_lock_sync || timer_reg >= RELOCK_CNT) begin
            timer_reg <= 16'h0000;
            state_reg <= ST_DONE;
          end else begin
            timer_reg <= timer_reg + 16'h0001;
          end
        end
        ST_READ: begin
          mailbox_read_data  <= read_word;
          mailbox_read_valid <= 1'b1;
          word_idx_reg       <= word_idx_reg + 3'h1;
          if (word_idx_reg == word_cnt_reg - 3'h1) begin
            status_code <= `STATUS_OK;
            state_reg   <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Status valid in the same cycle busy drops
          if (cmd_reg == `CMD_DIGEST && options_reg != {`OPT_WIDTH{1'b0}}) begin
            status_code <= fail_reg ? `STATUS_DIGEST_FAIL : `STATUS_OK;
          end
          status_valid <= 1'b1;
          service_busy <= 1'b0;
          state_reg    <= ST_IDLE;
        end
        default: begin
          state_reg    <= ST_IDLE;
          service_busy <= 1'b0;
        end
      endcase
    end
  end

  // Counter is enabled by fabric_clk_en, so it holds while gated
  always @(posedge clk_sys) begin
    if (rst) begin
      led_div_reg   <= 32'h00000000;
      led_count_reg <= `LED_COUNT_RESET;
      led_out       <= 4'h0;
    end else begin
      if (fabric_clk_en) begin
        if (led_div_reg >= LED_TICK_W - 32'h00000001) begin
          led_div_reg   <= 32'h00000000;
          led_count_reg <= led_count_reg + 4'h1;
        end else begin
          led_div_reg <= led_div_reg + 32'h00000001;
        end
      end
      led_out <= fabric_clk_en ? led_count_reg : 4'h0;
    end
  end
endmodule

// *** bench/pll_partner.sv ***
`timescale 1ns/1ps
module pll_partner (
  input  wire        clk_sys,
  input  wire        pll_power_down,
  input  wire [15:0] relock_cycles,
  output reg         pll_lock_in
);
  reg [15:0] cnt_reg;
  initial begin
    pll_lock_in = 1'b1;
    cnt_reg = 16'h0000;
  end
  always @(posedge clk_sys) begin
    if (pll_power_down) begin // Lock lost while powered down
      pll_lock_in <= 1'b0;
      cnt_reg <= 16'h0000;
    end else if (!pll_lock_in) begin // Relock is never instant
      cnt_reg <= cnt_reg + 16'h0001;
      if (cnt_reg >= relock_cycles)
        pll_lock_in <= 1'b1;
    end
  end
endmodule

module reset_partner (
  input  wire clk_sys,
  input  wire external_reset_n,
  input  wire pll_lock_in,
  input  wire init_done,
  input  wire service_busy,
  input  wire flop_restore_flag,
  output reg  design_rst
);
  // Busy and restore hide lock loss and the pin around resume
  wire hold = service_busy || flop_restore_flag;
  wire src  = !init_done || (!hold && (!pll_lock_in || !external_reset_n));
  reg  meta_reg;
  always @(posedge clk_sys or posedge src) begin
    if (src) begin // Asserts at once, releases on the clock
      meta_reg   <= 1'b1;
      design_rst <= 1'b1;
    end else begin
      meta_reg   <= 1'b0;
      design_rst <= meta_reg;
    end
  end
endmodule

// *** bench/digest_checker_props.sv ***
`timescale 1ns/1ps
module digest_checker #(
  parameter integer LED_TICK = 4
) (
  input wire        clk_sys,
  input wire        rst,
  input wire        service_req,
  input wire [7:0]  service_cmd,
  input wire [7:0]  mailbox_write_data,
  input wire        digest_fail_in,
  input wire        pll_lock_in,
  input wire        service_busy,
  input wire [7:0]  status_code,
  input wire        status_valid,
  input wire [31:0] mailbox_read_data,
  input wire        mailbox_read_valid,
  input wire        flop_restore_flag,
  input wire        fabric_clk_en,
  input wire        pll_power_down,
  input wire        io_input_en,
  input wire [3:0]  led_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire take = service_req && !service_busy;
  wire odd = service_cmd != 8'h00 && service_cmd != 8'h01 && service_cmd != 8'h47;
  a_busy_on_take: assert property (take |=> service_busy)
    else $error("busy not raised");
  a_valid_drops_busy: assert property (status_valid |-> $fell(service_busy))
    else $error("status without busy fall");
  a_fall_gives_status: assert property ($fell(service_busy) |-> status_valid)
    else $error("busy fell silently");
  a_suspend_gates: assert property (pll_power_down |-> !fabric_clk_en && !io_input_en)
    else $error("suspend incomplete");
  a_leds_dark: assert property (!fabric_clk_en && $past(!fabric_clk_en) |-> led_out == 4'h0)
    else $error("leds lit in suspend");
  a_restore_pulse: assert property (flop_restore_flag |-> fabric_clk_en ##1 !flop_restore_flag)
    else $error("restore flag bad");
  a_resume_restore: assert property ($rose(fabric_clk_en) |-> ##[0:1] flop_restore_flag)
    else $error("no restore at resume");
  a_user_code: assert property (take && service_cmd == 8'h01 |->
    ##2 mailbox_read_valid ##1 status_valid && status_code == 8'h00)
    else $error("user code timing");
  a_serial_words: assert property (take && service_cmd == 8'h00 |->
    ##2 mailbox_read_valid [*4] ##1 status_valid)
    else $error("serial word count");
  a_bad_command: assert property (take && odd |-> ##2 status_valid && status_code == 8'hFF)
    else $error("bad command status");
  c_suspend: cover property (pll_power_down);
  c_restore: cover property (flop_restore_flag);
  c_fail: cover property (status_valid && status_code == 8'h01);
endmodule
bind digest_service_engine digest_checker #(.LED_TICK(LED_TICK)) u_chk (
  .clk_sys, .rst, .service_req, .service_cmd, .mailbox_write_data, .digest_fail_in,
  .pll_lock_in, .service_busy, .status_code, .status_valid, .mailbox_read_data,
  .mailbox_read_valid, .flop_restore_flag, .fabric_clk_en, .pll_power_down,
  .io_input_en, .led_out
);

// *** bench/digest_service_engine_tb.sv ***
`timescale 1ns/1ps
`include "digest_service_defs.vh"
module digest_service_engine_tb;
  localparam [127:0] SID = 128'h0123456789ABCDEF0011223344556677; // Arbitrary value
  localparam [31:0]  UC  = 32'hA5C3F00D;
  reg         clk_sys = 1'b0;
  reg         rst = 1'b1;
  reg         service_req = 1'b0;
  reg  [7:0]  service_cmd = 8'h00;
  reg  [7:0]  mailbox_write_data = 8'h00;
  reg         digest_fail_in = 1'b0;
  reg  [15:0] relock = 16'h0004;
  reg  [7:0]  rnd;
  reg  [3:0]  held;
  reg         pe, pe2;
  reg         design_reset_request_n = 1'b1;
  reg         device_reset_gate_n = 1'b0;
  wire        design_rst;
  wire        pll_lock_in, service_busy, status_valid, mailbox_read_valid;
  wire        flop_restore_flag, fabric_clk_en, pll_power_down, io_input_en;
  wire [7:0]  status_code;
  wire [31:0] mailbox_read_data;
  wire [3:0]  led_out;
  integer     n_fail = 0, checked = 0, cyc = 0, i, n_susp, n_rest, n_drst;
  digest_service_engine #(.SERIAL_ID_VALUE(SID), .USER_CODE_VALUE(UC), .LED_TICK(4)) DUT (
    .clk_sys, .rst, .service_req, .service_cmd, .mailbox_write_data, .digest_fail_in,
    .pll_lock_in, .service_busy, .status_code, .status_valid, .mailbox_read_data,
    .mailbox_read_valid, .flop_restore_flag, .fabric_clk_en, .pll_power_down,
    .io_input_en, .led_out
  );
  pll_partner u_pll (.clk_sys, .pll_power_down, .relock_cycles(relock), .pll_lock_in);
  reset_partner u_rst (
    .clk_sys, .external_reset_n(design_reset_request_n), .pll_lock_in, .init_done(!rst),
    .service_busy, .flop_restore_flag, .design_rst
  );
  always #12.5 clk_sys = ~clk_sys;
  task conclude;
    begin
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Ten digests of about 4000 cycles each fit well inside this
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      conclude;
    end
  end
  task chk(input [31:0] exp, input [31:0] got, input [8*8:1] what);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected %0s exp %0h got %0h", what, exp, got);
      end
    end
  endtask
  function [7:0] exp_st(input [7:0] c, input [7:0] o, input f);
    exp_st = (c == `CMD_SERIAL_ID || c == `CMD_USER_CODE) ? `STATUS_OK :
             (c != `CMD_DIGEST) ? `STATUS_BAD_CMD : (o == 8'h00) ? `STATUS_NO_AREA :
             f ? `STATUS_DIGEST_FAIL : `STATUS_OK;
  endfunction
  task run(input [7:0] c, input [7:0] o, input intr);
    integer k, w;
    begin
      @(negedge clk_sys);
      service_cmd = c;
      mailbox_write_data = o;
      service_req = 1'b1;
      @(negedge clk_sys);
      service_req = 1'b0;
      k = 0;
      w = 0;
      n_susp = 0;
      n_rest = 0;
      n_drst = 0;
      pe = 1'b1;
      pe2 = 1'b1;
      while (status_valid !== 1'b1 && k < 9000) begin
        @(negedge clk_sys);
        k = k + 1;
        service_req = intr && k == 3; // Stray request while busy
        if (mailbox_read_valid === 1'b1) begin
          chk((c == `CMD_USER_CODE) ? UC : SID[32*w +: 32], mailbox_read_data, "word");
          w = w + 1;
        end
        if (pll_power_down === 1'b1 && fabric_clk_en === 1'b0 && io_input_en === 1'b0)
          n_susp = n_susp + 1;
        if (fabric_clk_en === 1'b0 && pe === 1'b1)
          held = led_out;
        // LEDs show the resumed count one cycle after the clocks return
        if (fabric_clk_en === 1'b1 && pe === 1'b1 && pe2 === 1'b0)
          chk(1, ((led_out - held) & 4'hF) <= 4'h1, "led");
        if (flop_restore_flag === 1'b1)
          n_rest = n_rest + 1;
        if (design_rst !== 1'b0)
          n_drst = n_drst + 1;
        pe2 = pe;
        pe = fabric_clk_en;
      end
      chk(1, status_valid, "valid");
      chk(exp_st(c, o, digest_fail_in), status_code, "status");
      chk(0, service_busy, "busy");
      chk(c == `CMD_SERIAL_ID ? 4 : c == `CMD_USER_CODE, w, "words");
      chk(c == `CMD_DIGEST && o[0], n_susp > 0, "suspend");
      chk(c == `CMD_DIGEST && o[0], n_rest, "restore");
      chk(0, n_drst, "drst");
      @(negedge clk_sys);
      chk(0, status_valid, "pulse");
    end
  endtask
  task reset_choice(input [7:0] key);
    begin
      @(negedge clk_sys);
      chk(0, service_busy, "idle");
      held = led_out;
      if (key == "1" && !device_reset_gate_n)
        rst = 1'b1; // Device reset only through logic
      else
        design_reset_request_n = 1'b0;
      #1;
      chk(1, design_rst, "assert");
      @(negedge clk_sys);
      if (key == "1")
        chk(0, led_out, "leds");
      else
        chk(1, ((led_out - held) & 4'hF) <= 4'h1, "leds");
      rst = 1'b0; // Single pulse
      design_reset_request_n = 1'b1;
      @(negedge clk_sys);
      chk(1, design_rst, "hold");
      @(negedge clk_sys);
      chk(0, design_rst, "release");
      if (key == "1") begin
        repeat (3) @(negedge clk_sys);
        chk(1, led_out, "count");
      end
    end
  endtask
  initial begin
    rnd = $urandom(29205);
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    chk({4'h0, 3'b101, 1'b0, 8'h00},
        {led_out, fabric_clk_en, pll_power_down, io_input_en, service_busy, status_code}, "reset");
    run(`CMD_USER_CODE, 8'h00, 1'b0);
    run(`CMD_SERIAL_ID, 8'h00, 1'b1);
    run(8'h5A, 8'h01, 1'b0);
    run(`CMD_DIGEST, 8'h00, 1'b0);
    for (i = 0; i < 8; i = i + 1) begin
      rnd = $urandom;
      digest_fail_in = rnd[0];
      relock = {10'h000, rnd[6:1]} + 16'h0002;
      run(`CMD_DIGEST, 8'h01 << i, 1'b0);
    end
    rnd = $urandom;
    digest_fail_in = 1'b1;
    run(`CMD_DIGEST, rnd | 8'h01, 1'b0);
    reset_choice("2");
    run(`CMD_DIGEST, 8'h01, 1'b0);
    reset_choice("1");
    run(`CMD_USER_CODE, 8'h00, 1'b0);
    conclude;
  end
endmodule
